// ---- design/bccce_bit_unit.sv ----
// Combinational data unit for bit test, toggle, clear and complement.
`timescale 1ns/1ps
module bccce_bit_unit
  import bccce_pkg::*;
(
  // Operand and selection.
  input  wire logic [7:0] operand,
  input  wire logic [2:0] bit_sel,
  input  wire bccce_bu_t  op,
  // Results.
  output logic [7:0]      result,
  output logic            bit_val,
  output logic            is_zero
);

  logic [7:0] mask;

  // Forms the selected bit and the operation result.
  always_comb begin
    mask    = 8'h01 << bit_sel;
    bit_val = operand[bit_sel];
    unique case (op)
      BU_PASS:   result = operand;
      BU_TOGGLE: result = operand ^ mask;
      BU_CLEAR:  result = CLEAR_VALUE;
      BU_INVERT: result = ~operand;
    endcase
    is_zero = (result == CLEAR_VALUE);
  end

endmodule // bccce_bit_unit

// ---- design/bccce_exec.sv ----
// Execution slice: decodes and runs bit test, toggle, call, clear and complement.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module bccce_exec
  import bccce_pkg::*;
(
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Register port.
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  // Program memory.
  output logic [15:0]           prog_addr,
  input  wire logic [15:0]      instr_word,
  // Data register file.
  output bccce_file_req_t       file_req,
  input  wire logic [7:0]       file_rdata,
  // Working register write.
  output logic                  working_register_wr,
  output logic [7:0]            working_register_wdata,
  // Hardware stack push.
  output logic                  stack_push,
  output logic [15:0]           stack_top_data,
  // Watchdog.
  output logic                  watchdog_timer_clear,
  input  wire logic             watchdog_timeout_evt,
  input  wire logic             sleep_entry_evt,
  // Status flags and upper PC latch.
  output logic                  watchdog_expiry_flag_n,
  output logic                  power_down_flag_n,
  output logic                  zero_flag,
  output logic [7:0]            upper_pc_latch
);

  // Phase pulses.
  logic q1;
  logic q2;
  logic q3;
  logic q4;

  // Fetch and program flow state.
  logic [15:0]     pc_ff;
  logic [15:0]     nxt_pc;
  logic [15:0]     ir_ff;
  logic [15:0]     nxt_ir;
  logic            kill_ff;
  logic            nxt_kill;
  logic [7:0]      upc_ff;
  logic [7:0]      nxt_upc;
  logic            run_ff;
  logic            nxt_run;

  // Execution state.
  bccce_op_t       op;
  bccce_bu_t       bu_op;
  logic [7:0]      bu_result;
  logic            bu_bit;
  logic            bu_zero;
  logic            skip_ff;
  logic            nxt_skip;
  logic            zres_ff;
  logic            nxt_zres;

  // Output registers.
  bccce_file_req_t req_ff;
  bccce_file_req_t nxt_req;
  logic            wwr_ff;
  logic            nxt_wwr;
  logic [7:0]      wdat_ff;
  logic [7:0]      nxt_wdat;
  logic            push_ff;
  logic            nxt_push;
  logic [15:0]     tos_ff;
  logic [15:0]     nxt_tos;
  logic            wclr_ff;
  logic            nxt_wclr;

  // Flags and register port read data.
  logic            zero_ff;
  logic            nxt_zero;
  logic            exp_n_ff;
  logic            nxt_exp_n;
  logic            pd_n_ff;
  logic            nxt_pd_n;
  logic [31:0]     rdata_ff;
  logic [31:0]     nxt_rdata;

  // Phase generator, halted while the run bit is low.
  bccce_phase_gen u_phase (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (run_ff),
    .q1      (q1),
    .q2      (q2),
    .q3      (q3),
    .q4      (q4)
  );

  // A killed word decodes as a no-operation.
  // no register access
  assign op = kill_ff ? OP_NONE : bccce_decode(ir_ff);

  // Selects the data unit operation from the decoded instruction.
  always_comb begin
    unique case (op)
      OP_BTG:  bu_op = BU_TOGGLE;
      OP_CLEAR_FILE_REG: bu_op = BU_CLEAR;
      OP_COMPLEMENT_FILE_REG: bu_op = BU_INVERT;
      default: bu_op = BU_PASS;
    endcase
  end

  // Data unit working on the operand returned by the register file.
  bccce_bit_unit u_bits (
    .operand (file_rdata),
    .bit_sel (ir_ff[FLD_BIT_MSB:FLD_BIT_LSB]),
    .op      (bu_op),
    .result  (bu_result),
    .bit_val (bu_bit),
    .is_zero (bu_zero)
  );

  // Program counter, fetch register, kill marker and upper latch.
  always_comb begin
    nxt_pc   = pc_ff;
    nxt_ir   = ir_ff;
    nxt_kill = kill_ff;
    nxt_upc  = upc_ff;
    if (q4) begin
      nxt_pc   = pc_ff + PC_STEP;
      nxt_ir   = instr_word;
      nxt_kill = 1'b0;
      if (op == OP_BTSS && skip_ff) begin
        nxt_kill = 1'b1;
      end
      if (op == OP_CALL) begin
        nxt_pc   = {pc_ff[15:PC_PAGE_LSB], ir_ff[FLD_LIT_MSB:0]};
        nxt_upc  = {pc_ff[15:PC_PAGE_LSB], ir_ff[FLD_LIT_MSB:FLD_LIT_HI]};
        nxt_kill = 1'b1;
      end
    end
  end

  // Registers program flow state; the first word after reset is discarded.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pc_ff   <= RST_PC;
      ir_ff   <= RST_INSTR;
      kill_ff <= 1'b1;
      upc_ff  <= RST_UPC;
    end else begin
      pc_ff   <= nxt_pc;
      ir_ff   <= nxt_ir;
      kill_ff <= nxt_kill;
      upc_ff  <= nxt_upc;
    end
  end

  // Phase work: read strobe in Q2, process in Q3, write strobe in Q4.
  always_comb begin
    nxt_req       = req_ff;
    nxt_req.rd    = 1'b0;
    nxt_req.wr    = 1'b0;
    nxt_wwr       = 1'b0;
    nxt_wdat      = wdat_ff;
    nxt_push      = 1'b0;
    nxt_tos       = tos_ff;
    nxt_wclr      = 1'b0;
    nxt_skip      = skip_ff;
    nxt_zres      = zres_ff;
    if (q1) begin
      nxt_req.addr = ir_ff[FLD_FILE_MSB:FLD_FILE_LSB];
      nxt_req.rd   = (op == OP_BTSS) || (op == OP_BTG) ||
                     (op == OP_CLEAR_FILE_REG) || (op == OP_COMPLEMENT_FILE_REG);
      nxt_skip     = 1'b0;
      if (op == OP_CALL) begin
        nxt_push = 1'b1;
        nxt_tos  = pc_ff;
      end
    end
    // Process in Q3 and stage the Q4 write.
    if (q3) begin
      nxt_req.wdata = bu_result;
      nxt_wdat      = bu_result;
      nxt_zres      = bu_zero;
      unique case (op)
        OP_BTSS: nxt_skip = bu_bit;
        OP_BTG: nxt_req.wr = 1'b1;
        OP_CLEAR_FILE_REG: begin
          nxt_req.wr = 1'b1;
          nxt_wwr    = !ir_ff[FLD_DEST];
        end
        OP_COMPLEMENT_FILE_REG: begin
          nxt_req.wr = ir_ff[FLD_DEST];
          nxt_wwr    = !ir_ff[FLD_DEST];
        end
        OP_CLEAR_WATCHDOG: nxt_wclr = 1'b1;
        default: nxt_skip = 1'b0;
      endcase
    end
  end

  // Registers the phase work outputs.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_ff  <= '0;
      wwr_ff  <= 1'b0;
      wdat_ff <= CLEAR_VALUE;
      push_ff <= 1'b0;
      tos_ff  <= RST_PC;
      wclr_ff <= 1'b0;
      skip_ff <= 1'b0;
      zres_ff <= 1'b0;
    end else begin
      req_ff  <= nxt_req;
      wwr_ff  <= nxt_wwr;
      wdat_ff <= nxt_wdat;
      push_ff <= nxt_push;
      tos_ff  <= nxt_tos;
      wclr_ff <= nxt_wclr;
      skip_ff <= nxt_skip;
      zres_ff <= nxt_zres;
    end
  end

  // Status flags; a timeout or sleep event wins over a same-cycle watchdog clear.
  always_comb begin
    nxt_zero  = zero_ff;
    nxt_exp_n = exp_n_ff;
    nxt_pd_n  = pd_n_ff;
    if (q4 && op == OP_COMPLEMENT_FILE_REG) begin
      nxt_zero = zres_ff;
    end
    if (q4 && op == OP_CLEAR_WATCHDOG) begin
      nxt_exp_n = 1'b1;
      nxt_pd_n  = 1'b1;
    end
    // Events are applied last so that a clear in the same cycle never hides them.
    if (watchdog_timeout_evt) nxt_exp_n = 1'b0;
    if (sleep_entry_evt)      nxt_pd_n  = 1'b0;
  end

  // Registers the flags.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      zero_ff  <= 1'b0;
      exp_n_ff <= RST_FLAG_N;
      pd_n_ff  <= RST_FLAG_N;
    end else begin
      zero_ff  <= nxt_zero;
      exp_n_ff <= nxt_exp_n;
      pd_n_ff  <= nxt_pd_n;
    end
  end

  // Register port: control write and read data one cycle after the strobe.
  always_comb begin
    nxt_run   = run_ff;
    nxt_rdata = '0;
    if (reg_wr && reg_addr == OFS_CTRL) begin
      nxt_run = reg_wdata[CTRL_RUN];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL:   nxt_rdata[CTRL_RUN] = run_ff;
        OFS_STATUS: begin
          nxt_rdata[STAT_ZERO]     = zero_ff;
          nxt_rdata[STAT_WDT_EXP]  = exp_n_ff;
          nxt_rdata[STAT_PWR_DOWN] = pd_n_ff;
        end
        OFS_PC:     nxt_rdata[15:0] = pc_ff;
        OFS_UPC:    nxt_rdata[7:0]  = upc_ff;
        OFS_INSTR:  nxt_rdata[15:0] = ir_ff;
        default:    nxt_rdata = '0;
      endcase
    end
  end

  // Registers the port state; read data stands for one cycle only.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_ff   <= RST_RUN;
      rdata_ff <= '0;
    end else begin
      run_ff   <= nxt_run;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs, all from flip-flops.
  assign reg_rdata              = rdata_ff;
  assign prog_addr              = pc_ff;
  assign file_req               = req_ff;
  assign working_register_wr    = wwr_ff;
  assign working_register_wdata = wdat_ff;
  assign stack_push             = push_ff;
  assign stack_top_data         = tos_ff;
  assign watchdog_timer_clear   = wclr_ff;
  assign watchdog_expiry_flag_n = exp_n_ff;
  assign power_down_flag_n      = pd_n_ff;
  assign zero_flag              = zero_ff;
  assign upper_pc_latch         = upc_ff;

endmodule // bccce_exec

// ---- design/bccce_phase_gen.sv ----
// Four-phase instruction cycle generator giving one-cycle phase pulses.
`timescale 1ns/1ps
module bccce_phase_gen
  import bccce_pkg::*;
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Phase advance enable.
  input  wire logic run,
  // Phase pulses, one clock each.
  output logic      q1,
  output logic      q2,
  output logic      q3,
  output logic      q4
);

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bccce_phase_t;

  bccce_phase_t phase_ff;
  bccce_phase_t nxt_phase;

  // Steps through the four phases while the core runs.
  always_comb begin
    nxt_phase = phase_ff;
    if (run) begin
      unique case (phase_ff)
        PH_Q1: nxt_phase = PH_Q2;
        PH_Q2: nxt_phase = PH_Q3;
        PH_Q3: nxt_phase = PH_Q4;
        PH_Q4: nxt_phase = PH_Q1;
      endcase
    end
  end

  // Registers the phase.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) phase_ff <= PH_Q1;
    else        phase_ff <= nxt_phase;
  end

  // Pulses are gated by run so a halted core does nothing.
  assign q1 = run && (phase_ff == PH_Q1);
  assign q2 = run && (phase_ff == PH_Q2);
  assign q3 = run && (phase_ff == PH_Q3);
  assign q4 = run && (phase_ff == PH_Q4);

endmodule // bccce_phase_gen

// ---- design/bccce_pkg.sv ----
// Package with encodings, offsets, reset values and shared types of the execution slice.
package bccce_pkg;

  // Opcode masks and patterns of the decoded instructions.
  localparam logic [15:0] OPM_BIT_TEST_SKIP_SET = 16'hf800;
  localparam logic [15:0] OPP_BIT_TEST_SKIP_SET = 16'h9000;
  localparam logic [15:0] OPM_BIT_TOGGLE        = 16'hf800;
  localparam logic [15:0] OPP_BIT_TOGGLE        = 16'h3800;
  localparam logic [15:0] OPM_CALL              = 16'he000;
  localparam logic [15:0] OPP_CALL              = 16'he000;
  localparam logic [15:0] OPM_CLEAR_FILE_REG    = 16'hfe00;
  localparam logic [15:0] OPP_CLEAR_FILE_REG    = 16'h2800;
  localparam logic [15:0] OPM_CLEAR_WATCHDOG    = 16'hffff;
  localparam logic [15:0] OPP_CLEAR_WATCHDOG    = 16'h0004;
  localparam logic [15:0] OPM_COMPLEMENT_FILE   = 16'hfe00;
  localparam logic [15:0] OPP_COMPLEMENT_FILE   = 16'h1200;

  // Field positions inside the instruction word.
  localparam int FLD_FILE_LSB  = 0;
  localparam int FLD_FILE_MSB  = 7;
  localparam int FLD_BIT_LSB   = 8;
  localparam int FLD_BIT_MSB   = 10;
  localparam int FLD_DEST      = 8;
  localparam int FLD_LIT_MSB   = 12;
  localparam int FLD_LIT_HI    = 8;
  localparam int PC_PAGE_LSB   = 13;

  // Register port offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC     = 8'h08;
  localparam logic [7:0] OFS_UPC    = 8'h0c;
  localparam logic [7:0] OFS_INSTR  = 8'h10;

  // Control and status field positions.
  localparam int CTRL_RUN      = 0;
  localparam int STAT_ZERO     = 0;
  localparam int STAT_WDT_EXP  = 1;
  localparam int STAT_PWR_DOWN = 2;

  // Reset values, the clear value and the program counter step.
  localparam logic [15:0] RST_PC       = 16'h0000;
  localparam logic [7:0]  RST_UPC      = 8'h00;
  localparam logic [15:0] RST_INSTR    = 16'h0000;
  localparam logic        RST_RUN      = 1'b0;
  localparam logic        RST_FLAG_N   = 1'b1;
  localparam logic [7:0]  CLEAR_VALUE  = 8'h00;
  localparam logic [15:0] PC_STEP      = 16'h0001;

  // Decoded operations of this slice; anything else runs as a no-operation.
  typedef enum logic [2:0] {
    OP_NONE, OP_BTSS, OP_BTG, OP_CALL, OP_CLEAR_FILE_REG, OP_CLEAR_WATCHDOG, OP_COMPLEMENT_FILE_REG
  } bccce_op_t;

  // Bit unit operations.
  typedef enum logic [1:0] {BU_PASS, BU_TOGGLE, BU_CLEAR, BU_INVERT} bccce_bu_t;

  // Request toward the data register file.
  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } bccce_file_req_t;

  // Decodes one instruction word into an operation.
  function automatic bccce_op_t bccce_decode(input logic [15:0] w);
    bccce_op_t op;
    op = OP_NONE;
    if ((w & OPM_CALL) == OPP_CALL) op = OP_CALL;
    else if ((w & OPM_BIT_TEST_SKIP_SET) == OPP_BIT_TEST_SKIP_SET) op = OP_BTSS;
    else if ((w & OPM_BIT_TOGGLE) == OPP_BIT_TOGGLE) op = OP_BTG;
    else if ((w & OPM_CLEAR_FILE_REG) == OPP_CLEAR_FILE_REG) op = OP_CLEAR_FILE_REG;
    else if ((w & OPM_CLEAR_WATCHDOG) == OPP_CLEAR_WATCHDOG) op = OP_CLEAR_WATCHDOG;
    else if ((w & OPM_COMPLEMENT_FILE) == OPP_COMPLEMENT_FILE) op = OP_COMPLEMENT_FILE_REG;
    return op;
  endfunction

endpackage

// ---- sim/bccce_exec_props.sv ----
// Port timing checker of the execution slice.
`timescale 1ns/1ps
module bccce_exec_props
  import bccce_pkg::*;
(
  // Clock and reset.
  input wire logic            sys_clk,
  input wire logic            rst_n,
  // Observed ports.
  input wire logic [15:0]     prog_addr,
  input wire bccce_file_req_t file_req,
  input wire logic            working_register_wr,
  input wire logic            stack_push,
  input wire logic [15:0]     stack_top_data,
  input wire logic            watchdog_timer_clear,
  input wire logic            watchdog_timeout_evt,
  input wire logic            sleep_entry_evt,
  input wire logic            watchdog_expiry_flag_n,
  input wire logic            power_down_flag_n,
  input wire logic [7:0]      upper_pc_latch
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // One cycle with no file access.
  sequence s_no_access;
    !file_req.rd && !file_req.wr;
  endsequence

  // A read of the same place two cycles earlier.
  sequence s_read_before;
    $past(file_req.rd, 2) && ($past(file_req.addr, 2) == file_req.addr);
  endsequence

  chk_killed_quiet:
    assert property (stack_push |=> s_no_access [*6]) else $error("access in killed cycle");
  chk_rd_spacing:
    assert property (file_req.rd |=> !file_req.rd [*3]) else $error("reads too close");
  chk_wr_after_rd:
    assert property (file_req.wr |-> s_read_before) else $error("write without read");
  chk_working_register_after_rd:
    assert property (working_register_wr |-> $past(file_req.rd, 2)) else $error("bad w write");
  chk_call_length:
    assert property (stack_push |=> !stack_push [*7]) else $error("call too short");
  chk_clear_single:
    assert property (watchdog_timer_clear |=> !watchdog_timer_clear [*3]) else $error("clr pulse");
  chk_clear_flags:
    assert property ((watchdog_timer_clear && !watchdog_timeout_evt && !sleep_entry_evt) |=>
                     (watchdog_expiry_flag_n && power_down_flag_n))
      else $error("flags not set");
  chk_flag_cause:
    assert property ($fell(watchdog_expiry_flag_n) |-> $past(watchdog_timeout_evt))
      else $error("flag fell alone");
  chk_latch_page:
    assert property (stack_push |-> ##3
                     (upper_pc_latch == {stack_top_data[15:13], prog_addr[12:8]}))
      else $error("latch page wrong");
  chk_pc_page:
    assert property (stack_push |-> ##3 (prog_addr[15:13] == stack_top_data[15:13]))
      else $error("call left page");
endmodule // bccce_exec_props

bind bccce_exec bccce_exec_props i_bccce_exec_props (
  .sys_clk, .rst_n, .prog_addr, .file_req, .working_register_wr, .stack_push,
  .stack_top_data, .watchdog_timer_clear, .watchdog_timeout_evt, .sleep_entry_evt,
  .watchdog_expiry_flag_n, .power_down_flag_n, .upper_pc_latch
);

// ---- sim/bccce_exec_test.sv ----
// Self-checking bench of the execution slice.
`timescale 1ns/1ps
module bccce_exec_test;
  import bccce_pkg::*;
  logic            sys_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [7:0]      reg_addr = 8'h00;
  logic [31:0]     reg_wdata = 32'h0;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic            watchdog_timeout_evt = 1'b0;
  logic            sleep_entry_evt = 1'b0;
  logic [31:0]     reg_rdata, rd;
  logic [15:0]     prog_addr, instr_word, stack_top_data, sp_data;
  bccce_file_req_t file_req;
  logic [7:0]      file_rdata, working_register_wdata, upper_pc_latch;
  logic            working_register_wr, stack_push, watchdog_timer_clear;
  logic            watchdog_expiry_flag_n, power_down_flag_n, zero_flag;
  logic [2:0]      st_push;
  logic [7:0]      w_q[$];
  int              num_errors = 0;
  int              n_checks = 0;
  int              n_clr = 0;
  int              pushed = 0;
  logic [15:0]     prog [0:10] = '{16'h1211, 16'h1310, 16'h2912, 16'h2813, 16'h3c14,
                                   16'h9115, 16'h2916, 16'h9015, 16'h0004, 16'hf234, 16'h2917};
  logic [7:0]      f_init [0:8] = '{8'hff, 8'h0f, 8'h77, 8'h77, 8'h75, 8'h02, 8'h5a, 8'h33, 8'h00};
  logic [7:0]      f_exp [0:8] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h65, 8'h02, 8'h5a, 8'h33, 8'hff};

  // Core clock.
  always #5 sys_clk = ~sys_clk;

  bccce_exec i_bccce_exec (
    .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prog_addr,
    .instr_word, .file_req, .file_rdata, .working_register_wr, .working_register_wdata,
    .stack_push, .stack_top_data, .watchdog_timer_clear, .watchdog_timeout_evt,
    .sleep_entry_evt, .watchdog_expiry_flag_n, .power_down_flag_n, .zero_flag, .upper_pc_latch
  );

  bccce_mem_model i_bccce_mem_model (
    .sys_clk, .prog_addr, .instr_word, .file_req, .file_rdata
  );

  // Records working-register writes, watchdog clears and the call push.
  always @(posedge sys_clk) begin
    if (rst_n && working_register_wr === 1'b1) w_q.push_back(working_register_wdata);
    if (rst_n && watchdog_timer_clear === 1'b1) n_clr++;
    if (rst_n && stack_push === 1'b1) begin
      pushed++;
      sp_data = stack_top_data;
      st_push = {power_down_flag_n, watchdog_expiry_flag_n, zero_flag};
    end
  end

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One write cycle on the register port.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // One read cycle; data are taken in the following cycle.
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (2000) @(posedge sys_clk);
    num_errors++;
    give_verdict;
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++) i_bccce_mem_model.pmem[i] = prog[i];
    i_bccce_mem_model.pmem[16'h1234] = 16'h1318;
    for (int i = 0; i < 9; i++) i_bccce_mem_model.fmem[8'h10 + i] = f_init[i];
    reg_read(OFS_STATUS, rd);
    chk(rd, 32'h6, "status reset");
    reg_read(OFS_UPC, rd);
    chk(rd, 32'h0, "latch reset");
    reg_write(8'h20, 32'hff);
    reg_read(8'h20, rd);
    chk(rd, 32'h0, "unmapped read");
    @(posedge sys_clk);
    watchdog_timeout_evt <= 1'b1;
    sleep_entry_evt <= 1'b1;
    @(posedge sys_clk);
    watchdog_timeout_evt <= 1'b0;
    sleep_entry_evt <= 1'b0;
    reg_read(OFS_STATUS, rd);
    chk(rd, 32'h0, "flags low");
    reg_write(OFS_CTRL, 32'h1);
    for (int i = 0; i < 300 && pushed == 0; i++) @(posedge sys_clk);
    chk(pushed, 1, "call push");
    chk(sp_data, 32'h000a, "return address");
    chk(st_push, 3'b111, "flags at call");
    repeat (40) @(posedge sys_clk);
    reg_write(OFS_CTRL, 32'h0);
    reg_read(OFS_STATUS, rd);
    chk(rd, 32'h6, "status end");
    reg_read(OFS_UPC, rd);
    chk(rd, 32'h12, "upper latch");
    reg_read(OFS_PC, rd);
    chk({rd[31:8], 8'h00}, 32'h1200, "call target");
    chk(n_clr, 1, "watchdog clears");
    chk(w_q.size(), 2, "w writes");
    chk(w_q[0], 8'hf0, "w complement");
    chk(w_q[1], 8'h00, "w cleared");
    for (int i = 0; i < 9; i++) chk(i_bccce_mem_model.fmem[8'h10 + i], f_exp[i], "file");
    chk(i_bccce_mem_model.fmem[8'h16], 8'h5a, "skipped word");
    chk(i_bccce_mem_model.fmem[8'h17], 8'h33, "killed word");
    give_verdict;
  end
endmodule // bccce_exec_test

// ---- sim/bccce_mem_model.sv ----
// Program memory and data register file facing the execution slice.
`timescale 1ns/1ps
module bccce_mem_model
  import bccce_pkg::*;
(
  // Clock.
  input  wire logic            sys_clk,
  // Program side.
  input  wire logic [15:0]     prog_addr,
  output logic [15:0]          instr_word,
  // File side.
  input  wire bccce_file_req_t file_req,
  output logic [7:0]           file_rdata
);
  logic [15:0] pmem [0:65535];
  logic [7:0]  fmem [0:255];

  // Cleared memories make unused words run as no-operation.
  initial begin
    for (int i = 0; i < 65536; i++) pmem[i] = 16'h0000;
    for (int i = 0; i < 256; i++) fmem[i] = 8'h00;
    file_rdata = 8'h00;
  end

  // Fetch answers at once.
  assign instr_word = pmem[prog_addr];

  // read then write
  // Read data stand only in the cycle after a read; else the bus toggles.
  always @(posedge sys_clk) begin
    if (file_req.rd) file_rdata <= fmem[file_req.addr];
    else file_rdata <= ~file_rdata;
    if (file_req.wr) fmem[file_req.addr] <= file_req.wdata;
  end
endmodule // bccce_mem_model
